// File: rtrx_pkg.sv
// rtrx_pkg: opcodes, field positions and reset values for the
// register transfer and ram address execution slice.
// assumes 10-bit instruction words from program memory.
package rtrx_pkg;

	localparam int IW_W   = 10;
	localparam int NIB_W  = 4;
	localparam int EXT_W  = 8;
	localparam int DREG_W = 3;
	localparam int BANK_W = 2;
	localparam int STK_W  = 3;

	// single-word opcodes
	localparam logic [IW_W-1:0] OP_COPY_B_TO_ACC    = 10'h01e;
	localparam logic [IW_W-1:0] OP_COPY_ACC_TO_B    = 10'h00e;
	localparam logic [IW_W-1:0] OP_COPY_ROW_TO_ACC  = 10'h01f;
	localparam logic [IW_W-1:0] OP_COPY_ACC_TO_ROW  = 10'h00c;
	localparam logic [IW_W-1:0] OP_LOAD_EXT_FROM_PR = 10'h01a;
	localparam logic [IW_W-1:0] OP_SPLIT_EXT_TO_PR  = 10'h02a;
	localparam logic [IW_W-1:0] OP_LOAD_DREG        = 10'h029;
	localparam logic [IW_W-1:0] OP_READ_DREG        = 10'h051;
	localparam logic [IW_W-1:0] OP_READ_BANK        = 10'h053;
	localparam logic [IW_W-1:0] OP_READ_COL         = 10'h052;
	localparam logic [IW_W-1:0] OP_READ_STACK_INDEX = 10'h050;
	localparam logic [IW_W-1:0] OP_INCR_ROW_SKIP    = 10'h013;
	localparam logic [IW_W-1:0] OP_DECR_ROW_SKIP    = 10'h017;

	// load_bank_imm: 0x048..0x04b, immediate in the low two bits
	localparam logic [IW_W-1:0] OP_LOAD_BANK_BASE   = 10'h048;
	localparam int              BANK_IMM_LSB        = 0;

	// load_col_row_imm: top two bits 11
	localparam int              LXY_TAG_LSB         = 8;
	localparam logic [1:0]      LXY_TAG             = 2'h3;
	localparam int              COL_IMM_LSB         = 4;
	localparam int              ROW_IMM_LSB         = 0;

	// nibble halves of the ext register
	localparam int              EXT_HI_LSB          = 4;
	localparam int              EXT_LO_LSB          = 0;

	// row step, and the row wrap values that raise a skip
	localparam logic [NIB_W-1:0] ROW_INC_WRAP       = 4'h0;
	localparam logic [NIB_W-1:0] ROW_DEC_WRAP       = 4'hf;
	localparam logic [NIB_W-1:0] ROW_STEP           = 4'h1;

	// reset values
	localparam logic [NIB_W-1:0]  RST_NIB           = 4'h0;
	localparam logic [EXT_W-1:0]  RST_EXT           = 8'h00;
	localparam logic [DREG_W-1:0] RST_DREG          = 3'h0;
	localparam logic [BANK_W-1:0] RST_BANK          = 2'h0;

	typedef struct packed {
		logic [NIB_W-1:0]  acc;
		logic [NIB_W-1:0]  breg;
		logic [NIB_W-1:0]  row;
		logic [NIB_W-1:0]  col;
		logic [BANK_W-1:0] bank;
		logic [DREG_W-1:0] dreg;
		logic [EXT_W-1:0]  ext;
		logic              skip_pend;
		logic              lxy_last;
		logic              squashed;
		logic              handled;
	} rtrx_state_t;

endpackage : rtrx_pkg

// File: rtrx_exec.sv
// rtrx_exec: executes transfer and ram address instructions in one
// cycle each. assumes the fetch unit presents one word per accepted
// cycle and the stack index comes from the call stack logic.
`timescale 1ns/1ns

module rtrx_exec (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	input  wire logic                        ce,
	// instruction from program memory
	input  wire logic [rtrx_pkg::IW_W-1:0]   instr_word,
	input  wire logic                        instr_valid,
	// stack index from call stack logic
	input  wire logic [rtrx_pkg::STK_W-1:0]  stack_index,
	// carry flag passes by untouched
	input  wire logic                        carry_flag_in,
	output logic                             carry_flag,
	// architectural registers
	output logic [rtrx_pkg::NIB_W-1:0]       acc,
	output logic [rtrx_pkg::NIB_W-1:0]       breg,
	output logic [rtrx_pkg::NIB_W-1:0]       row,
	output logic [rtrx_pkg::NIB_W-1:0]       col,
	output logic [rtrx_pkg::BANK_W-1:0]      bank,
	output logic [rtrx_pkg::DREG_W-1:0]      dreg,
	output logic [rtrx_pkg::EXT_W-1:0]       ext,
	// sequencing status
	output logic                             skip_pending,
	output logic                             squashed,
	output logic                             handled
);
	import rtrx_pkg::*;

	rtrx_state_t st_r;
	rtrx_state_t st_nxt;

	// col/row decoding shared by the skip chain and the execute path, bank decoding by the execute path only
	function automatic logic is_col_row_load(
		input logic [IW_W-1:0] w
	);
		is_col_row_load = (w[IW_W-1:LXY_TAG_LSB] == LXY_TAG);
	endfunction : is_col_row_load

	function automatic logic is_bank_load(
		input logic [IW_W-1:0] w
	);
		is_bank_load = (w[IW_W-1:BANK_W] == OP_LOAD_BANK_BASE[IW_W-1:BANK_W]);
	endfunction : is_bank_load

	logic take;
	logic lxy_now;
	logic chain_skip;
	logic run;

	assign take       = ce & instr_valid;
	assign lxy_now    = is_col_row_load(instr_word);
	// a skipped column/row load still extends the chain
	assign chain_skip = st_r.lxy_last & lxy_now;
	assign run        = take & ~st_r.skip_pend & ~chain_skip;

	always_comb begin
		st_nxt          = st_r;
		st_nxt.squashed = 1'h0;
		st_nxt.handled  = 1'h0;
		if (take) begin
			st_nxt.lxy_last  = lxy_now;
			st_nxt.skip_pend = 1'h0;
			st_nxt.squashed  = st_r.skip_pend | chain_skip;
		end
		if (run) begin
			if (lxy_now) begin
				st_nxt.col     = instr_word[COL_IMM_LSB +: NIB_W];
				st_nxt.row     = instr_word[ROW_IMM_LSB +: NIB_W];
				st_nxt.handled = 1'h1;
			end else if (is_bank_load(instr_word)) begin
				st_nxt.bank    = instr_word[BANK_IMM_LSB +: BANK_W];
				st_nxt.handled = 1'h1;
			end else begin
				st_nxt.handled = 1'h1;
				case (instr_word)
				OP_COPY_B_TO_ACC: begin
					st_nxt.acc = st_r.breg;
				end
				OP_COPY_ACC_TO_B: begin
					st_nxt.breg = st_r.acc;
				end
				OP_COPY_ROW_TO_ACC: begin
					st_nxt.acc = st_r.row;
				end
				OP_COPY_ACC_TO_ROW: begin
					st_nxt.row = st_r.acc;
				end
				OP_LOAD_EXT_FROM_PR: begin
					st_nxt.ext = {st_r.breg, st_r.acc};
				end
				OP_SPLIT_EXT_TO_PR: begin
					st_nxt.breg = st_r.ext[EXT_HI_LSB +: NIB_W];
					st_nxt.acc  = st_r.ext[EXT_LO_LSB +: NIB_W];
				end
				OP_LOAD_DREG: begin
					// acc bit 3 is dropped on purpose
					st_nxt.dreg = st_r.acc[DREG_W-1:0];
				end
				OP_READ_DREG: begin
					st_nxt.acc = {1'h0, st_r.dreg};
				end
				OP_READ_BANK: begin
					st_nxt.acc = {2'h0, st_r.bank};
				end
				OP_READ_COL: begin
					st_nxt.acc = st_r.col;
				end
				OP_READ_STACK_INDEX: begin
					st_nxt.acc = {1'h0, stack_index};
				end
				OP_INCR_ROW_SKIP: begin
					st_nxt.row       = st_r.row + ROW_STEP;
					st_nxt.skip_pend = ((st_r.row + ROW_STEP) == ROW_INC_WRAP);
				end
				OP_DECR_ROW_SKIP: begin
					st_nxt.row       = st_r.row - ROW_STEP;
					st_nxt.skip_pend = ((st_r.row - ROW_STEP) == ROW_DEC_WRAP);
				end
				default: begin
					// word belongs to another execution slice
					st_nxt.handled = 1'h0;
				end
				endcase
			end
		end
	end

	// ce low freezes every field, pulses included
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.acc       <= RST_NIB;
			st_r.breg      <= RST_NIB;
			st_r.row       <= RST_NIB;
			st_r.col       <= RST_NIB;
			st_r.bank      <= RST_BANK;
			st_r.dreg      <= RST_DREG;
			st_r.ext       <= RST_EXT;
			st_r.skip_pend <= 1'h0;
			st_r.lxy_last  <= 1'h0;
			st_r.squashed  <= 1'h0;
			st_r.handled   <= 1'h0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// no instruction here writes carry
	assign carry_flag   = carry_flag_in;
	assign acc          = st_r.acc;
	assign breg         = st_r.breg;
	assign row          = st_r.row;
	assign col          = st_r.col;
	assign bank         = st_r.bank;
	assign dreg         = st_r.dreg;
	assign ext          = st_r.ext;
	assign skip_pending = st_r.skip_pend;
	assign squashed     = st_r.squashed;
	assign handled      = st_r.handled;

endmodule : rtrx_exec

// File: rtrx_exec_props.sv
// rtrx_exec_props: port assertions for the exec slice.
// assumes one clock domain and async active-low reset.
`timescale 1ns/1ns
module rtrx_exec_props (
	// clock, reset and inputs
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic       ce,
	input wire logic [9:0] instr_word,
	input wire logic       instr_valid,
	input wire logic       carry_flag_in,
	// observed state
	input wire logic       carry_flag,
	input wire logic [3:0] acc,
	input wire logic [3:0] breg,
	input wire logic [3:0] row,
	input wire logic [7:0] ext,
	input wire logic       skip_pending,
	input wire logic       squashed
);
	import rtrx_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic run;
	// only words that are neither pending-skip nor idle
	assign run = ce && instr_valid && !skip_pending;
	sequence s_col_row;
		ce && instr_valid && instr_word[9:8] == LXY_TAG;
	endsequence
	property p_tab; run && instr_word == OP_COPY_B_TO_ACC |=> acc == $past(breg); endproperty
	a_tab: assert property (p_tab) else $error("acc not from breg");
	property p_tba; run && instr_word == OP_COPY_ACC_TO_B |=> breg == $past(acc) && acc == $past(acc); endproperty
	a_tba: assert property (p_tba) else $error("breg not from acc");
	property p_ext; run && instr_word == OP_LOAD_EXT_FROM_PR |=> ext == {$past(breg), $past(acc)}; endproperty
	a_ext: assert property (p_ext) else $error("ext halves wrong");
	property p_inc; run && instr_word == OP_INCR_ROW_SKIP && row == 4'hf |=> row == 4'h0 && skip_pending; endproperty
	a_inc: assert property (p_inc) else $error("row increment wrap");
	property p_dec; run && instr_word == OP_DECR_ROW_SKIP && row == 4'h0 |=> row == 4'hf && skip_pending; endproperty
	a_dec: assert property (p_dec) else $error("row decrement wrap");
	property p_skp; ce && instr_valid && skip_pending |=> squashed && !skip_pending && $stable(acc); endproperty
	a_skp: assert property (p_skp) else $error("pending skip ignored");
	property p_chain; s_col_row ##1 s_col_row |=> squashed && $stable(row); endproperty
	a_chain: assert property (p_chain) else $error("second col row load ran");
	property p_cy; carry_flag == carry_flag_in; endproperty
	a_cy: assert property (p_cy) else $error("carry altered");
	property p_tay; run && instr_word == OP_COPY_ROW_TO_ACC |=> acc == $past(row); endproperty
	a_tay: assert property (p_tay) else $error("acc not from row");
	property p_tya; run && instr_word == OP_COPY_ACC_TO_ROW |=> row == $past(acc); endproperty
	a_tya: assert property (p_tya) else $error("row not from acc");
	// enable low must hold state and the squashed pulse alike
	property p_hold; !ce |=> $stable(acc) && $stable(row) && $stable(squashed); endproperty
	a_hold: assert property (p_hold) else $error("state moved while enable low");
endmodule : rtrx_exec_props
bind rtrx_exec rtrx_exec_props u_props (.*);

// File: rtrx_pmem.sv
// rtrx_pmem: program memory model, one word per address.
// assumes the bench steps the address once a cycle.
`timescale 1ns/1ns
module rtrx_pmem (
	// fetch address
	input wire logic [4:0]            pc,
	// word to the slice
	output logic [rtrx_pkg::IW_W-1:0] instr_word
);
	import rtrx_pkg::*;
	localparam logic [IW_W-1:0] PROG [0:31] = '{10'h3a5, 10'h312, 10'h01f, 10'h00e, 10'h3c3, 10'h01f,
		10'h01a, 10'h052, 10'h029, 10'h051, 10'h04b, 10'h053, 10'h050, 10'h02a, 10'h01e, 10'h3bf,
		10'h01f, 10'h013, 10'h01e, 10'h017, 10'h00c, 10'h01e, 10'h00c, 10'h050, 10'h21e, 10'h04c,
		10'h013, 10'h3e1, 10'h01f, 10'h377, 10'h3a5, 10'h3c3};
	// every address holds a word, so a wrapped fetch is never stale
	assign instr_word = PROG[pc];
endmodule : rtrx_pmem

// File: tb_reg_transfer_ram_addr_exec.sv
// tb_reg_transfer_ram_addr_exec: steps a fixed program, checks state.
// assumes rtrx_pmem holds the program in the order checked here.
`timescale 1ns/1ns
module tb_reg_transfer_ram_addr_exec;
	import rtrx_pkg::*;
	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic       valid = 1'b0;
	logic [4:0] pc = 5'h00;
	logic [9:0] word;
	logic [3:0] acc, breg, row, col;
	logic [7:0] ext;
	logic [2:0] dreg;
	logic [1:0] bank;
	logic       cy, skp, sq;
	logic       ce = 1'b1;
	logic [2:0] stk = 3'h7;
	logic       hd;
	int         err_total = 0;
	int         samples_checked = 0;
	always #2 mclk = ~mclk;
	rtrx_pmem pm (.pc(pc), .instr_word(word));
	rtrx_exec dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .instr_word(word), .instr_valid(valid),
		.stack_index(stk), .carry_flag_in(pc[0]), .carry_flag(cy), .acc(acc), .breg(breg), .row(row),
		.col(col), .bank(bank), .dreg(dreg), .ext(ext), .skip_pending(skp), .squashed(sq), .handled(hd));
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// results of word pc-1 are settled after this
	task step;
		@(negedge mclk) pc = pc + 5'h01;
	endtask : step
	task sa(input logic [3:0] e);
		step;
		cmp(acc, e);
	endtask : sa
	task t_col_row;
		step;
		cmp({col, row}, 8'ha5);
		step;
		cmp({row, 3'h0, sq}, 8'h51);
		sa(4'h5);
	endtask : t_col_row
	task t_moves;
		step;
		cmp(breg, 8'h05);
		step;
		cmp({col, row}, 8'hc3);
		sa(4'h3);
		step;
		cmp(ext, 8'h53);
		sa(4'hc);
		step;
		cmp(dreg, 8'h04);
		sa(4'h4);
		step;
		cmp(bank, 8'h03);
		sa(4'h3);
		sa(4'h7);
		step;
		cmp({breg, acc}, 8'h53);
		sa(4'h5);
	endtask : t_moves
	task t_skip;
		step;
		sa(4'hf);
		step;
		cmp({row, 3'h0, skp}, 8'h01);
		step;
		cmp({acc, 3'h0, sq}, 8'hf1);
		step;
		cmp({row, 3'h0, skp}, 8'hf1);
		step;
		cmp({row, 3'h0, sq}, 8'hf1);
		step;
		cmp({acc, 3'h0, sq}, 8'h50);
		cmp(cy, pc[0]);
		step;
		cmp(row, 8'h05);
	endtask : t_skip
	// foreign words must leave every register alone
	task t_foreign;
		stk = 3'h2;
		step;
		cmp({acc, 3'h0, hd}, 8'h21);
		step;
		cmp({acc, 2'h0, hd, sq}, 8'h20);
		step;
		cmp({bank, 5'h0, hd}, 8'hc0);
		step;
		cmp({row, 2'h0, skp, hd}, 8'h61);
	endtask : t_foreign
	task t_freeze;
		step;
		cmp({col, row}, 8'he1);
		ce = 1'b0;
		repeat (3) begin
			@(negedge mclk);
			cmp({acc, row}, 8'h21);
			cmp({7'h0, hd}, 8'h01);
		end
		ce = 1'b1;
		step;
		cmp({acc, 3'h0, hd}, 8'h11);
	endtask : t_freeze
	// reset in mid-run must also break the column/row chain
	task t_reset;
		step;
		cmp({col, row}, 8'h77);
		arst_n = 1'b0;
		repeat (2) @(negedge mclk);
		cmp({acc, breg}, {RST_NIB, RST_NIB});
		cmp({row, col}, {RST_NIB, RST_NIB});
		cmp(ext, RST_EXT);
		cmp({bank, dreg, skp, sq, hd}, {RST_BANK, RST_DREG, 3'h0});
		arst_n = 1'b1;
		step;
		cmp({col, row}, 8'ha5);
		step;
		cmp({row, 3'h0, sq}, 8'h51);
	endtask : t_reset
	task results;
		$display("mismatches %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (20) @(negedge mclk);
		arst_n = 1'b1;
		cmp(ext, RST_EXT);
		valid = 1'b1;
		t_col_row;
		t_moves;
		t_skip;
		t_foreign;
		t_freeze;
		t_reset;
		results;
	end
endmodule : tb_reg_transfer_ram_addr_exec
